// ---- common/freq_ctrl_pkg.sv ----
// Constants and carrier types for the overclocking frequency control registers.
// Assumes a byte-wide register port driven by a management bus front end elsewhere.
package freq_ctrl_pkg;

  // ==========================================================================
  // Register offsets and reset values
  localparam logic [7:0] OFS_CPU_N_HIGH_AND_M_VALUE = 8'h0f;
  localparam logic [7:0] OFS_SERIAL_REF_N_LOW       = 8'h10;
  localparam logic [7:0] OFS_WD_RESTORE_N_LOW       = 8'h11;
  localparam logic [7:0] OFS_FREQ_MODE_ENABLES      = 8'h12;
  localparam logic [7:0] REG_RESET_VALUE            = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE        = 8'h00;

  // ==========================================================================
  // Field positions
  localparam int CPU_N_HIGH_BIT   = 7;
  localparam int EN_SREF_N8_BIT   = 7;
  localparam int EN_OVERRIDE_BIT  = 6;
  localparam int EN_DYN_FREQ_BIT  = 5;
  localparam int EN_EXT_RESET_BIT = 4;
  localparam int EN_PROG_SREF_BIT = 3;
  localparam int EN_PROG_CPU_BIT  = 2;
  localparam int EN_AUTO_RECV_BIT = 1;
  localparam int EN_RECV_N8_BIT   = 0;

  // ==========================================================================
  // Codes
  localparam logic [1:0] DYN_SEL_ORIGINAL = 2'h0;
  localparam logic [1:0] DYN_SEL_ONE      = 2'h1;
  localparam logic [1:0] DYN_SEL_TWO      = 2'h2;
  localparam logic [1:0] DYN_SEL_THREE    = 2'h3;
  localparam logic [1:0] STRAP_DOT_CODE   = 2'h1;
  localparam logic [1:0] STRAP_SATA_CODE  = 2'h3;

  typedef enum logic [1:0] {
    PIN_A_LINK,
    PIN_A_DOT,
    PIN_A_SATA
  } shared_pin_a_t;

  typedef enum logic {
    PIN_B_SATA,
    PIN_B_PCIE
  } shared_pin_b_t;

  // CPU PLL setting handed to the analog PLL control
  typedef struct packed {
    logic       prog_active;
    logic [8:0] cpu_pll_n_value;
    logic [6:0] cpu_pll_m_value;
    logic [3:0] ratio_select;
    logic       dyn_active;
  } cpu_pll_cfg_t;

  typedef struct packed {
    logic       prog_active;
    logic [8:0] serial_ref_pll_n_value;
  } sref_pll_cfg_t;

  typedef struct packed {
    logic       auto_recovery;
    logic [8:0] restore_n;
  } wd_recovery_t;

  typedef struct packed {
    shared_pin_a_t pin_a;
    shared_pin_b_t pin_b;
  } shared_route_t;

endpackage : freq_ctrl_pkg

// ---- rtl/freq_ctrl_regs.sv ----
// Control registers for CPU and serial-reference PLL programming, recovery N,
// mode enables, and the platform strap routing of two shared output pins.
// Assumes reg_wr/reg_rd are single-cycle strobes from a management bus slave
// synchronous to ref_clk, and all pin inputs are synchronous to ref_clk.
`timescale 1ns/1ps

module freq_ctrl_regs
  import freq_ctrl_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          reg_wr,
  input  wire logic          reg_rd,
  input  wire logic [7:0]    reg_addr,
  input  wire logic [7:0]    reg_wdata,
  output logic      [7:0]    reg_rdata,
  input  wire logic [3:0]    soft_freq_select,
  input  wire logic [3:0]    freq_select_pins,
  input  wire logic [4:0]    latched_strap_freq_select,
  input  wire logic [1:0]    dyn_select_pins,
  input  wire logic [8:0]    dyn_n_value_one,
  input  wire logic [8:0]    dyn_n_value_two,
  input  wire logic [8:0]    dyn_n_value_three,
  input  wire logic [1:0]    platform_strap,
  input  wire logic          ext_reset_in_n,
  output cpu_pll_cfg_t       cpu_cfg,
  output sref_pll_cfg_t      sref_cfg,
  output wd_recovery_t       recovery,
  output logic [3:0]         operating_freq_select,
  output logic               ext_reset_req,
  output shared_route_t      shared_route
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]    cpu_n_high_and_m_value;
    logic [7:0]    serial_ref_n_low;
    logic [7:0]    wd_restore_n_low;
    logic [7:0]    freq_mode_enables;
    logic [7:0]    rdata;
    cpu_pll_cfg_t  cpu;
    sref_pll_cfg_t sref;
    wd_recovery_t  recv;
    logic [3:0]    op_soft_freq_select;
    logic          ext_rst;
    shared_route_t route;
  } state_t;

  state_t state_q;
  state_t state_d;

  localparam state_t STATE_RESET = '{
    cpu_n_high_and_m_value: REG_RESET_VALUE,
    serial_ref_n_low:       REG_RESET_VALUE,
    wd_restore_n_low:       REG_RESET_VALUE,
    freq_mode_enables:      REG_RESET_VALUE,
    route:                  '{pin_a: PIN_A_LINK, pin_b: PIN_B_SATA},
    default:                '0
  };

  // ==========================================================================
  // Helpers
  function automatic logic [8:0] join_n(input logic hi, input logic [7:0] lo);
    join_n = {hi, lo};
  endfunction : join_n

  function automatic logic [7:0] read_mux(input state_t s, input logic [7:0] a);
    unique case (a)
      OFS_CPU_N_HIGH_AND_M_VALUE: read_mux = s.cpu_n_high_and_m_value;
      OFS_SERIAL_REF_N_LOW:       read_mux = s.serial_ref_n_low;
      OFS_WD_RESTORE_N_LOW:       read_mux = s.wd_restore_n_low;
      OFS_FREQ_MODE_ENABLES:      read_mux = s.freq_mode_enables;
      default:                    read_mux = UNMAPPED_READ_VALUE;
    endcase
  endfunction : read_mux

  // ==========================================================================
  // Next state
  always_comb begin
    logic [7:0] en;
    logic [8:0] base_n;
    state_d = state_q;
    en      = '0;
    base_n  = '0;

    // Plain storage; the host owns load ordering of N and M
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_CPU_N_HIGH_AND_M_VALUE: state_d.cpu_n_high_and_m_value = reg_wdata;
        OFS_SERIAL_REF_N_LOW:       state_d.serial_ref_n_low       = reg_wdata;
        OFS_WD_RESTORE_N_LOW:       state_d.wd_restore_n_low       = reg_wdata;
        OFS_FREQ_MODE_ENABLES:      state_d.freq_mode_enables      = reg_wdata;
        default: ;
      endcase
    end
    // Read data reflects the registers as they stood before a same-cycle write
    if (reg_rd) begin
      state_d.rdata = read_mux(state_q, reg_addr);
    end

    // Outputs follow the registered values, so they lag a write by one cycle
    en = state_q.freq_mode_enables;

    // CPU N: upper bit from register 0x0f, low byte from the preceding register
    // is outside this block, so the low byte is tied to 8'h00 here.
    base_n = join_n(state_q.cpu_n_high_and_m_value[CPU_N_HIGH_BIT], 8'h00);
    state_d.cpu.prog_active     = en[EN_PROG_CPU_BIT];
    state_d.cpu.cpu_pll_m_value = en[EN_PROG_CPU_BIT] ?
                                  state_q.cpu_n_high_and_m_value[6:0] : 7'h00;
    state_d.cpu.dyn_active      = en[EN_DYN_FREQ_BIT];
    if (en[EN_DYN_FREQ_BIT]) begin
      unique case (dyn_select_pins)
        DYN_SEL_ORIGINAL: state_d.cpu.cpu_pll_n_value = en[EN_PROG_CPU_BIT] ? base_n : 9'h000;
        DYN_SEL_ONE:      state_d.cpu.cpu_pll_n_value = dyn_n_value_one;
        DYN_SEL_TWO:      state_d.cpu.cpu_pll_n_value = dyn_n_value_two;
        DYN_SEL_THREE:    state_d.cpu.cpu_pll_n_value = dyn_n_value_three;
      endcase
    end else begin
      state_d.cpu.cpu_pll_n_value = en[EN_PROG_CPU_BIT] ? base_n : 9'h000;
    end
    // Ratio: latched strap code (low four bits) unless overridden by software
    state_d.cpu.ratio_select = en[EN_OVERRIDE_BIT] ? soft_freq_select
                                                   : latched_strap_freq_select[3:0];
    state_d.op_soft_freq_select = en[EN_OVERRIDE_BIT] ? soft_freq_select : freq_select_pins;

    state_d.sref.prog_active            = en[EN_PROG_SREF_BIT];
    state_d.sref.serial_ref_pll_n_value = en[EN_PROG_SREF_BIT] ?
        join_n(en[EN_SREF_N8_BIT], state_q.serial_ref_n_low) : 9'h000;

    state_d.recv.restore_n     = join_n(en[EN_RECV_N8_BIT], state_q.wd_restore_n_low);
    state_d.recv.auto_recovery = en[EN_AUTO_RECV_BIT];

    state_d.ext_rst = en[EN_EXT_RESET_BIT] & ~ext_reset_in_n;

    unique case (platform_strap)
      STRAP_DOT_CODE:  state_d.route.pin_a = PIN_A_DOT;
      STRAP_SATA_CODE: state_d.route.pin_a = PIN_A_SATA;
      default:         state_d.route.pin_a = PIN_A_LINK;
    endcase
    state_d.route.pin_b = platform_strap[1] ? PIN_B_PCIE : PIN_B_SATA;
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q <= STATE_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata             = state_q.rdata;
  assign cpu_cfg               = state_q.cpu;
  assign sref_cfg              = state_q.sref;
  assign recovery              = state_q.recv;
  assign operating_freq_select = state_q.op_soft_freq_select;
  assign ext_reset_req         = state_q.ext_rst;
  assign shared_route          = state_q.route;

endmodule : freq_ctrl_regs

// ---- verif/freq_ctrl_regs_assertions.sv ----
// Checker bound to freq_ctrl_regs; it watches the block's ports only.
// Assumes derived outputs follow a taken write two edges later.
`timescale 1ns/1ps
module freq_ctrl_checker
  import freq_ctrl_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          rst,
  input wire logic          reg_wr,
  input wire logic          reg_rd,
  input wire logic [7:0]    reg_addr,
  input wire logic [7:0]    reg_wdata,
  input wire logic [7:0]    reg_rdata,
  input wire logic [1:0]    platform_strap,
  input wire logic          ext_reset_in_n,
  input wire cpu_pll_cfg_t  cpu_cfg,
  input wire sref_pll_cfg_t sref_cfg,
  input wire wd_recovery_t  recovery,
  input wire logic          ext_reset_req,
  input wire shared_route_t shared_route
);
  logic en_wr;
  assign en_wr = reg_wr && reg_addr == OFS_FREQ_MODE_ENABLES;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Register port, enables and strap routing
  AST_UNMAPPED_READ: assert property (reg_rd && reg_addr > 8'h12 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without a read");
  AST_PROG_CPU: assert property (en_wr |-> ##2 cpu_cfg.prog_active == $past(reg_wdata[2], 2))
    else $error("cpu enable wrong");
  AST_PROG_SREF: assert property (en_wr |-> ##2 {sref_cfg.prog_active,
    sref_cfg.serial_ref_pll_n_value[8]} == $past({reg_wdata[3], reg_wdata[3] & reg_wdata[7]}, 2))
    else $error("serial ref setting wrong");
  AST_RECOVERY: assert property (en_wr |-> ##2 {recovery.auto_recovery,
    recovery.restore_n[8]} == $past(reg_wdata[1:0], 2)) else $error("recovery wrong");
  AST_DYN_EN: assert property (en_wr |-> ##2 cpu_cfg.dyn_active == $past(reg_wdata[5], 2))
    else $error("dynamic enable wrong");
  AST_EXT_RESET: assert property (ext_reset_in_n |=> !ext_reset_req)
    else $error("reset request without input");
  AST_STRAP_B: assert property (1'b1 |=> shared_route.pin_b == $past(platform_strap[1]))
    else $error("second shared pin wrong");
endmodule : freq_ctrl_checker

bind freq_ctrl_regs freq_ctrl_checker u_checker (.*);

// ---- verif/freq_ctrl_regs_tb.sv ----
// Self-checking bench for freq_ctrl_regs driven through the host model.
// Assumes outputs settle within two edges of the write or pin change.
`timescale 1ns/1ps
module freq_ctrl_regs_tb
  import freq_ctrl_pkg::*;
;
  logic          ref_clk = 1'b0;
  logic          rst = 1'b1;
  logic          reg_wr, reg_rd;
  logic [7:0]    reg_addr, reg_wdata, reg_rdata, rd_val;
  logic [3:0]    soft_sel = 4'h9, pin_sel = 4'h3, op_sel;
  logic [1:0]    dyn_sel = 2'h0, strap = 2'h0;
  logic [8:0]    dyn_n [3] = '{9'h101, 9'h0a2, 9'h1c3};
  logic          ext_n = 1'b1, ext_req;
  cpu_pll_cfg_t  cpu_cfg;
  sref_pll_cfg_t sref_cfg;
  wd_recovery_t  recovery;
  shared_route_t route;
  int            miscompares = 0, comparisons = 0;
  always #2.5 ref_clk = ~ref_clk;
  mgmt_host host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  freq_ctrl_regs dut (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .soft_freq_select(soft_sel), .freq_select_pins(pin_sel), .latched_strap_freq_select(5'h16),
    .dyn_select_pins(dyn_sel), .dyn_n_value_one(dyn_n[0]), .dyn_n_value_two(dyn_n[1]),
    .dyn_n_value_three(dyn_n[2]), .platform_strap(strap), .ext_reset_in_n(ext_n),
    .cpu_cfg(cpu_cfg), .sref_cfg(sref_cfg), .recovery(recovery), .operating_freq_select(op_sel),
    .ext_reset_req(ext_req), .shared_route(route));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : settle
  task automatic give_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      host.rd(8'h0f + 8'(i), rd_val);
      chk(rd_val, 8'h00);
    end
    // N and M go in before any enable is set
    host.wr(8'h0f, 8'hd5);
    host.wr(8'h10, 8'h3c);
    host.wr(8'h11, 8'hc3);
    host.wr(8'h13, 8'hff);
    host.wr(8'h12, 8'h8d);
    host.rd(8'h0f, rd_val);
    chk(rd_val, 8'hd5);
    host.rd(8'h12, rd_val);
    chk(rd_val, 8'h8d);
    host.rd(8'h13, rd_val);
    chk(rd_val, 8'h00);
    chk({cpu_cfg.prog_active, cpu_cfg.cpu_pll_n_value[8], cpu_cfg.cpu_pll_m_value}, 9'h1d5);
    chk({sref_cfg.prog_active, sref_cfg.serial_ref_pll_n_value}, 10'h33c);
    chk(recovery, 10'h1c3);
    host.wr(8'h12, 8'h44);
    settle();
    chk({op_sel, cpu_cfg.ratio_select}, 8'h99);
    host.wr(8'h12, 8'h04);
    settle();
    chk({op_sel, cpu_cfg.ratio_select}, 8'h36);
    host.wr(8'h12, 8'h02);
    settle();
    chk({recovery.auto_recovery, cpu_cfg.prog_active, cpu_cfg.cpu_pll_m_value}, 9'h100);
    @(posedge ref_clk);
    ext_n <= 1'b0;
    host.wr(8'h12, 8'h10);
    settle();
    chk(ext_req, 1'b1);
    host.wr(8'h12, 8'h24);
    settle();
    chk({ext_req, cpu_cfg.dyn_active}, 2'h1);
    for (int s = 0; s < 4; s++) begin
      dyn_sel <= 2'(s);
      strap <= 2'(s);
      settle();
      chk(cpu_cfg.cpu_pll_n_value, s == 0 ? 9'h100 : dyn_n[s-1]);
      chk(route.pin_a, s == 1 ? PIN_A_DOT : s == 3 ? PIN_A_SATA : PIN_A_LINK);
      chk(route.pin_b, s > 1 ? PIN_B_PCIE : PIN_B_SATA);
    end
    @(posedge ref_clk);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    host.rd(8'h12, rd_val);
    chk(rd_val, 8'h00);
    give_verdict();
  end
endmodule : freq_ctrl_regs_tb

// ---- verif/mgmt_host.sv ----
// Management bus host model issuing one-cycle write and read strobes.
// Assumes the device takes a request on the edge that sees the strobe high.
`timescale 1ns/1ps
module mgmt_host (
  input  wire logic       ref_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // Data flips after release so a stale byte never passes as valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge ref_clk);
    {reg_wr, reg_wdata} <= {1'b0, ~d};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : mgmt_host
